/* pkg/cfg_loader_pkg.sv */
package cfg_loader_pkg;
	// Block type codes found in the high bits of the type byte
	localparam logic [1:0] BLK_SINGLE = 2'h0;
	localparam logic [1:0] BLK_SEQ = 2'h1;
	localparam logic [1:0] BLK_BAD = 2'h2;
	localparam logic [1:0] BLK_DONE = 2'h3;
	// Type field position in byte 1 of a block
	localparam int TYPE_LSB = 6;
	// Fixed bits of the EEPROM device address
	localparam logic [2:0] EE_ADDR_FIXED = 3'h5;
	// Prescaler reset values for the two SMBus rates
	localparam logic [7:0] PRESC_100K = 8'h18;
	localparam logic [7:0] PRESC_400K = 8'h06;
	// Checksum value of a good image
	localparam logic [7:0] CSUM_GOOD = 8'hFF;
	// Top EEPROM byte address; reading past it wraps
	localparam logic [15:0] EE_TOP = 16'hFFFF;
	// Switch mode codes that include EEPROM load
	localparam logic [3:0] MODE_NORMAL_EE = 4'h0;
	localparam logic [3:0] MODE_TEST_EE = 4'h1;
	// Lost arbitration limit
	localparam logic [4:0] ARB_LIMIT = 5'h10;
	// Write toward the register file
	typedef struct packed {
		logic [15:0] addr;
		logic [31:0] data;
	} reg_write_type;
	// Status bits
	typedef struct packed {
		logic unmapped_init_attempt;
		logic image_content_error;
		logic nack_error;
		logic lost_arbitration_error;
		logic other_bus_error;
		logic eeprom_load_done;
	} status_type;
endpackage : cfg_loader_pkg

/* src/cfg_fifo.sv */
`timescale 1ns/1ps
module cfg_fifo #(
	parameter int WIDTH = 48,
	parameter int DEPTH = 4
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_valid,
	output logic o_ready,
	input wire logic [WIDTH-1:0] i_data,
	output logic o_valid,
	input wire logic i_ready,
	output logic [WIDTH-1:0] o_data
);
	localparam int AW = $clog2(DEPTH);
	// Elaboration check: the wrap-bit full test only works for power-of-two depths
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_check
		$error("cfg_fifo depth must be a power of two, at least 2");
	end
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_q;
	logic [AW:0] rd_q;
	wire push = i_valid && o_ready;
	wire pop = o_valid && i_ready;
	// Full when pointers match except the wrap bit
	assign o_ready = (wr_q ^ rd_q) != {1'b1, {AW{1'b0}}};
	assign o_valid = wr_q != rd_q;
	assign o_data = mem[rd_q[AW-1:0]];
	// Storage has no reset; only pointers need a defined state
	always_ff @(posedge i_clk) begin
		if (push) begin
			mem[wr_q[AW-1:0]] <= i_data;
		end
	end
	// Pointer update
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			if (push) wr_q <= wr_q + {{AW{1'b0}}, 1'b1};
			if (pop) rd_q <= rd_q + {{AW{1'b0}}, 1'b1};
		end
	end
endmodule : cfg_fifo

/* src/cfg_loader.sv */
`timescale 1ns/1ps
// Notes on behaviour
// RULE_01: Slow strap picks 100K else 400K prescaler
// RULE_02: Run only when mode includes EEPROM load
// RULE_03: Device address is 101 plus straps
// RULE_04: Read from zero; stop at done or wrap
// RULE_05: Dword address gets two zero bits appended
// RULE_06: Type 0 is six-byte single write
// RULE_07: Address low then high; data LSB first
// RULE_08: Type 1 writes count consecutive dwords
// RULE_09: Count is 16 bits, LSB first
// RULE_10: Type 3 is done block, ends load
// RULE_11: Unmapped write dropped, flag set
// RULE_12: Running 8-bit sum must reach FF
// RULE_13: Image checksum is complement of sum
// RULE_14: Ignore bit masks checksum mismatch
// RULE_15: Any error aborts and sets reset halt
// RULE_16: Checksum mismatch sets content error
// RULE_17: Type 2 sets content error, aborts
// RULE_18: Unexpected NACK sets nack error, aborts
// RULE_19: Sixteen lost arbitrations set error, abort
// RULE_20: Misplaced START/STOP sets other error
// RULE_21: Done flag set on finish or abort
// RULE_22: Expander traffic held until load ends
// RULE_23: Clean load releases the switch hold
module cfg_loader #(
	parameter int FIFO_DEPTH = 4
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_hot_reset,
	input wire logic i_master_slow_mode_strap,
	input wire logic [3:0] i_switch_operating_mode,
	input wire logic [3:0] i_eeprom_address_straps,
	input wire logic i_ignore_checksum_errors,
	// Byte read engine toward the SMBus master
	output logic o_rd_req,
	output logic [6:0] o_rd_dev_addr,
	output logic [15:0] o_rd_byte_addr,
	input wire logic i_rd_ack,
	input wire logic [7:0] i_rd_data,
	input wire logic i_rd_nack,
	input wire logic i_rd_arb_lost,
	input wire logic i_rd_misplaced_cond,
	// Register write path
	output logic o_wr_valid,
	input wire logic i_wr_ready,
	output logic [15:0] o_wr_addr,
	output logic [31:0] o_wr_data,
	input wire logic i_wr_unmapped,
	// Status and control outputs
	output logic [7:0] o_master_clock_prescaler,
	output cfg_loader_pkg::status_type o_status,
	output logic o_reset_halt,
	output logic o_switch_hold,
	output logic o_expander_enable
);
	typedef enum {
		ST_IDLE, ST_ADDR_LO, ST_ADDR_HI, ST_CNT_LO, ST_CNT_HI,
		ST_DATA, ST_PUSH, ST_CSUM, ST_DONE_TYPE, ST_DRAIN, ST_FINISH
	} state_type;
	// Elaboration check on the write buffer depth
	if (FIFO_DEPTH < 2) begin : g_depth_check
		$error("cfg_loader FIFO depth must be at least 2");
	end

	state_type state_q, state_d;
	logic [15:0] ee_addr_q;
	logic [7:0] sum_q;
	logic [13:0] dw_addr_q;
	logic [1:0] type_q;
	logic [15:0] count_q;
	logic [1:0] byte_idx_q;
	logic [31:0] data_q;
	logic [4:0] arb_cnt_q;
	logic started_q;
	logic [7:0] presc_q;
	cfg_loader_pkg::status_type sts_q;
	logic halt_q;
	logic hold_q;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [47:0] fifo_out_data;
	cfg_loader_pkg::reg_write_type push_word;

	// Mode decode used at start of every reset
	function automatic logic mode_loads(input logic [3:0] m);
		return (m == cfg_loader_pkg::MODE_NORMAL_EE) || (m == cfg_loader_pkg::MODE_TEST_EE);
	endfunction : mode_loads

	// Byte fetch handshake
	wire byte_ok = i_rd_ack && !i_rd_nack;
	wire [7:0] sum_next = sum_q + i_rd_data;
	wire [1:0] type_field = i_rd_data[cfg_loader_pkg::TYPE_LSB +: 2];
	wire wrapped = ee_addr_q == cfg_loader_pkg::EE_TOP;
	wire fetching = (state_q == ST_ADDR_LO) || (state_q == ST_ADDR_HI) ||
		(state_q == ST_CNT_LO) || (state_q == ST_CNT_HI) ||
		(state_q == ST_DATA) || (state_q == ST_CSUM) || (state_q == ST_DONE_TYPE);
	// RULE_14 ignore bit masks mismatch
	wire csum_bad = (sum_next != cfg_loader_pkg::CSUM_GOOD) && !i_ignore_checksum_errors;
	// Errors from the bus engine abort any fetch
	wire err_nack = fetching && i_rd_nack;
	wire err_arb = fetching && i_rd_arb_lost && (arb_cnt_q == cfg_loader_pkg::ARB_LIMIT - 5'h01);
	wire err_other = fetching && i_rd_misplaced_cond;
	wire err_type = byte_ok && (state_q == ST_ADDR_HI) && (type_field == cfg_loader_pkg::BLK_BAD);
	// RULE_16 sum judged at the done type byte, the last byte it covers
	wire err_csum = byte_ok && (state_q == ST_ADDR_HI) &&
		(type_field == cfg_loader_pkg::BLK_DONE) && csum_bad;
	wire any_err = err_nack || err_arb || err_other || err_type || err_csum;
	wire last_byte = byte_idx_q == 2'h3;
	wire [31:0] data_full = {i_rd_data, data_q[31:8]};

	// Next-state logic
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (started_q && hold_q && !halt_q && !sts_q.eeprom_load_done) begin
					state_d = ST_ADDR_LO;
				end
			end
			ST_ADDR_LO: if (byte_ok) state_d = ST_ADDR_HI;
			ST_ADDR_HI: begin
				if (byte_ok) begin
					case (type_field)
						cfg_loader_pkg::BLK_SINGLE: state_d = ST_DATA;
						cfg_loader_pkg::BLK_SEQ: state_d = ST_CNT_LO;
						default: state_d = ST_ADDR_HI;
					endcase
				end
			end
			ST_CNT_LO: if (byte_ok) state_d = ST_CNT_HI;
			ST_CNT_HI: begin
				if (byte_ok) begin
					state_d = ({i_rd_data, count_q[7:0]} == 16'h0000) ? ST_ADDR_LO : ST_DATA;
				end
			end
			ST_DATA: if (byte_ok && last_byte) state_d = ST_PUSH;
			ST_PUSH: begin
				if (fifo_in_ready) begin
					state_d = ((type_q == cfg_loader_pkg::BLK_SEQ) && (count_q != 16'h0001)) ?
						ST_DATA : ST_ADDR_LO;
				end
			end
			ST_CSUM: if (byte_ok) state_d = ST_DONE_TYPE;
			ST_DONE_TYPE: if (byte_ok) state_d = ST_DRAIN;
			ST_DRAIN: if (!fifo_out_valid) state_d = ST_FINISH;
			ST_FINISH: state_d = ST_IDLE;
			default: state_d = ST_IDLE;
		endcase
		// RULE_10 done block ends load
		// Done block is recognised from its second byte, so reroute the address-high path
		if ((state_q == ST_ADDR_HI) && byte_ok && (type_field == cfg_loader_pkg::BLK_DONE)) begin
			state_d = ST_DRAIN;
		end
		// RULE_04 wrap stop
		if (fetching && byte_ok && wrapped && state_d != ST_DRAIN) begin
			state_d = ST_DRAIN;
		end
		// RULE_15 abort on error
		if (any_err) begin
			state_d = ST_DRAIN;
		end
	end

	// State and reset-hold bookkeeping
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_q <= ST_IDLE;
			started_q <= 1'b0;
		end else begin
			state_q <= i_hot_reset ? ST_IDLE : state_d;
			started_q <= 1'b1;
		end
	end

	// RULE_01 strap caught after release, not in reset
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			presc_q <= cfg_loader_pkg::PRESC_400K;
		end else if (!started_q) begin
			presc_q <= i_master_slow_mode_strap ? cfg_loader_pkg::PRESC_100K :
				cfg_loader_pkg::PRESC_400K;
		end
	end

	// RULE_02 hold the switch only when a load will run
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			hold_q <= 1'b1;
		end else if (!started_q || i_hot_reset) begin
			hold_q <= mode_loads(i_switch_operating_mode);
		end else if (state_q == ST_FINISH && !halt_q) begin
			// RULE_23 release after clean load
			hold_q <= 1'b0;
		end
	end

	// EEPROM address walk and running checksum
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ee_addr_q <= 16'h0000;
			sum_q <= 8'h00;
		end else if (state_q == ST_IDLE) begin
			// RULE_04 start at zero
			ee_addr_q <= 16'h0000;
			sum_q <= 8'h00;
		end else if (fetching && byte_ok) begin
			ee_addr_q <= ee_addr_q + 16'h0001;
			// RULE_12 running sum
			sum_q <= sum_next;
		end
	end

	// Block field capture
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			dw_addr_q <= 14'h0000;
			type_q <= 2'h0;
			count_q <= 16'h0000;
			byte_idx_q <= 2'h0;
			data_q <= 32'h0000_0000;
		end else if (byte_ok) begin
			case (state_q)
				// RULE_07 address bytes
				ST_ADDR_LO: dw_addr_q[7:0] <= i_rd_data;
				ST_ADDR_HI: begin
					dw_addr_q[13:8] <= i_rd_data[5:0];
					type_q <= type_field;
					// RULE_06 single block carries one dword
					count_q <= 16'h0001;
					byte_idx_q <= 2'h0;
				end
				// RULE_09 count LSB first
				ST_CNT_LO: count_q[7:0] <= i_rd_data;
				ST_CNT_HI: count_q[15:8] <= i_rd_data;
				ST_DATA: begin
					// RULE_07 data least significant byte first
					data_q <= data_full;
					byte_idx_q <= byte_idx_q + 2'h1;
				end
				default: data_q <= data_q;
			endcase
		end else if (state_q == ST_PUSH && fifo_in_ready) begin
			// RULE_08 advance to next dword
			dw_addr_q <= dw_addr_q + 14'h0001;
			count_q <= count_q - 16'h0001;
		end
	end

	// RULE_19 consecutive lost arbitration count
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			arb_cnt_q <= 5'h00;
		end else if (byte_ok || state_q == ST_IDLE) begin
			arb_cnt_q <= 5'h00;
		end else if (fetching && i_rd_arb_lost) begin
			arb_cnt_q <= arb_cnt_q + 5'h01;
		end
	end

	// Sticky status; errors cleared by reset only, done and halt also cleared by hot reset
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sts_q <= '0;
			halt_q <= 1'b0;
		end else begin
			// RULE_11 unmapped target flag
			if (o_wr_valid && i_wr_ready && i_wr_unmapped) sts_q.unmapped_init_attempt <= 1'b1;
			// RULE_16 RULE_17 content error
			if (err_csum || err_type) sts_q.image_content_error <= 1'b1;
			// RULE_18 nack error
			if (err_nack) sts_q.nack_error <= 1'b1;
			// RULE_19 arbitration error
			if (err_arb) sts_q.lost_arbitration_error <= 1'b1;
			// RULE_20 other bus error
			if (err_other) sts_q.other_bus_error <= 1'b1;
			// RULE_21 done on finish or abort
			if (state_q == ST_FINISH) sts_q.eeprom_load_done <= 1'b1;
			// RULE_15 halt on any error
			if (any_err) halt_q <= 1'b1;
			// RULE_02 hot reset reruns load; it outranks finish and halt, errors stay
			if (i_hot_reset) begin
				sts_q.eeprom_load_done <= 1'b0;
				halt_q <= 1'b0;
			end
		end
	end

	// RULE_05 byte address is dword address times four
	assign push_word.addr = {dw_addr_q, 2'b00};
	assign push_word.data = data_q;

	cfg_fifo #(
		.WIDTH(48),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_valid(state_q == ST_PUSH),
		.o_ready(fifo_in_ready),
		.i_data(push_word),
		.o_valid(fifo_out_valid),
		.i_ready(i_wr_ready),
		.o_data(fifo_out_data)
	);

	// Writes leave the FIFO; RULE_11 drop is done by the register file on unmapped
	assign o_wr_valid = fifo_out_valid;
	assign o_wr_addr = fifo_out_data[47:32];
	assign o_wr_data = fifo_out_data[31:0];

	// RULE_03 device address
	assign o_rd_dev_addr = {cfg_loader_pkg::EE_ADDR_FIXED, i_eeprom_address_straps};
	// Fetch is suppressed while a word waits in ST_PUSH, which stalls reads
	assign o_rd_req = fetching;
	assign o_rd_byte_addr = ee_addr_q;
	assign o_master_clock_prescaler = presc_q;
	assign o_status = sts_q;
	assign o_reset_halt = halt_q;
	assign o_switch_hold = hold_q;
	// RULE_22 expanders wait for load end
	assign o_expander_enable = !hold_q || sts_q.eeprom_load_done;
endmodule : cfg_loader

/* tb/cfg_loader_monitor.sv */
`timescale 1ns/1ps
// Port checker for the loader
module cfg_loader_monitor (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_hot_reset,
	input wire logic i_master_slow_mode_strap,
	input wire logic [3:0] i_eeprom_address_straps,
	input wire logic o_rd_req,
	input wire logic [6:0] o_rd_dev_addr,
	input wire logic [15:0] o_rd_byte_addr,
	input wire logic i_rd_ack,
	input wire logic i_rd_nack,
	input wire logic o_wr_valid,
	input wire logic i_wr_ready,
	input wire logic [15:0] o_wr_addr,
	input wire logic [31:0] o_wr_data,
	input wire cfg_loader_pkg::status_type o_status,
	input wire logic [7:0] o_master_clock_prescaler,
	input wire logic o_reset_halt,
	input wire logic o_switch_hold,
	input wire logic o_expander_enable
);
	logic seen_q;
	logic [15:0] last_q;
	wire logic [3:0] errs;
	wire logic dn;
	// Load errors only; the unmapped flag does not abort
	assign errs = o_status[4:1];
	assign dn = o_status.eeprom_load_done;
	// Last byte address taken, for the step check
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			seen_q <= 1'b0;
			last_q <= 16'h0000;
		end else if (i_hot_reset) begin
			// A hot reset starts the walk from zero again
			seen_q <= 1'b0;
		end else if (o_rd_req && i_rd_ack) begin
			seen_q <= 1'b1;
			last_q <= o_rd_byte_addr;
		end
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	a_dev_addr: assert property (o_rd_req |-> o_rd_dev_addr == {3'h5, i_eeprom_address_straps})
		else $error("device address wrong");
	a_addr_order: assert property (o_rd_req |->
		o_rd_byte_addr == (seen_q ? last_q + 16'h0001 : 16'h0000)) else $error("byte order wrong");
	a_req_stands: assert property (o_rd_req && !i_rd_ack && !i_rd_nack |=> $stable(o_rd_byte_addr))
		else $error("read address moved");
	a_wr_align: assert property (o_wr_valid |-> o_wr_addr[1:0] == 2'h0)
		else $error("write address not aligned");
	a_wr_holds: assert property (o_wr_valid && !i_wr_ready |=> o_wr_valid && $stable(o_wr_data))
		else $error("write dropped");
	a_nack_abort: assert property (o_rd_req && i_rd_nack |-> ##[1:8] o_status.nack_error)
		else $error("nack not flagged");
	a_halt_err: assert property (dn && errs != 4'h0 |-> o_reset_halt && o_switch_hold)
		else $error("error without halt");
	a_clean_release: assert property (dn && errs == 4'h0 |-> !o_switch_hold)
		else $error("hold kept");
	a_done_sticky: assert property (dn && !i_hot_reset |=> dn)
		else $error("done lost");
	a_presc_val: assert property (dn |-> o_master_clock_prescaler ==
		(i_master_slow_mode_strap ? cfg_loader_pkg::PRESC_100K : cfg_loader_pkg::PRESC_400K))
		else $error("prescaler wrong");
	a_expander_gate: assert property (o_rd_req |-> !o_expander_enable)
		else $error("expander early");
	c_clean: cover property (dn && errs == 4'h0);
	c_nack: cover property (o_status.nack_error);
	c_reload: cover property (dn && i_hot_reset ##1 !dn);
	c_wr_stall: cover property (o_wr_valid && !i_wr_ready ##1 o_wr_valid && i_wr_ready);
endmodule : cfg_loader_monitor
bind cfg_loader cfg_loader_monitor i_cfg_loader_monitor (.i_clk(i_clk), .i_rst_n(i_rst_n),
	.i_hot_reset(i_hot_reset),
	.i_master_slow_mode_strap(i_master_slow_mode_strap), .o_rd_req(o_rd_req),
	.i_eeprom_address_straps(i_eeprom_address_straps), .o_rd_dev_addr(o_rd_dev_addr),
	.o_rd_byte_addr(o_rd_byte_addr), .i_rd_ack(i_rd_ack), .i_rd_nack(i_rd_nack),
	.o_wr_valid(o_wr_valid), .i_wr_ready(i_wr_ready), .o_wr_addr(o_wr_addr), .o_wr_data(o_wr_data),
	.o_status(o_status), .o_master_clock_prescaler(o_master_clock_prescaler),
	.o_reset_halt(o_reset_halt), .o_switch_hold(o_switch_hold),
	.o_expander_enable(o_expander_enable));

/* tb/eeprom_model.sv */
`timescale 1ns/1ps
// Byte-read EEPROM with random answer delay
module eeprom_model (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_req,
	input wire logic [15:0] i_addr,
	input wire logic i_stall,
	input wire logic [15:0] i_nack_addr,
	output logic o_ack,
	output logic o_nack,
	output logic [7:0] o_data
);
	logic [7:0] mem [0:255];
	logic [1:0] wait_q;
	int seed = 79522;
	// Data toggles outside the answer cycle so stale bytes never look valid
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_ack <= 1'b0;
			o_nack <= 1'b0;
			o_data <= 8'h00;
			wait_q <= 2'h0;
		end else begin
			o_ack <= 1'b0;
			o_nack <= 1'b0;
			o_data <= ~o_data;
			if (i_req && !o_ack && !o_nack && !i_stall) begin
				if (wait_q != 2'h0) wait_q <= wait_q - 2'h1;
				else if (i_addr == i_nack_addr) o_nack <= 1'b1;
				else begin
					o_ack <= 1'b1;
					o_data <= mem[i_addr[7:0]];
					wait_q <= 2'($random(seed));
				end
			end
		end
	end
endmodule : eeprom_model

/* tb/test_smbus_eeprom_config_loader.sv */
`timescale 1ns/1ps
module test_smbus_eeprom_config_loader;
	logic clk = 0, rst_n = 0, strap = 0, ign = 0, arb = 0, misp = 0, rdy = 0, stall = 0, hot = 0;
	logic [3:0] mode = 4'h0, ast = 4'h0;
	logic [15:0] nack_at = 16'hFFFF, ba, wa;
	logic req, ack, nk, wv, halt, hold, xen;
	logic [6:0] dev;
	logic [7:0] rdat, presc, sum;
	logic [31:0] wd;
	cfg_loader_pkg::status_type st, ex;
	int error_cnt = 0, checked = 0, seed = 79522, n, k;
	logic [7:0] img [$];
	cfg_loader_pkg::reg_write_type exp_q [$];
	cfg_loader_pkg::reg_write_type exp_copy [$];
	always #50 clk = ~clk;
	cfg_loader i_cfg_loader (.i_clk(clk), .i_rst_n(rst_n), .i_hot_reset(hot),
		.i_master_slow_mode_strap(strap), .i_switch_operating_mode(mode),
		.i_eeprom_address_straps(ast), .i_ignore_checksum_errors(ign), .o_rd_req(req),
		.o_rd_dev_addr(dev), .o_rd_byte_addr(ba), .i_rd_ack(ack), .i_rd_data(rdat),
		.i_rd_nack(nk), .i_rd_arb_lost(arb), .i_rd_misplaced_cond(misp), .o_wr_valid(wv),
		.i_wr_ready(rdy), .o_wr_addr(wa), .o_wr_data(wd), .i_wr_unmapped(wa[15]),
		.o_master_clock_prescaler(presc), .o_status(st), .o_reset_halt(halt),
		.o_switch_hold(hold), .o_expander_enable(xen));
	eeprom_model i_eeprom_model (.i_clk(clk), .i_rst_n(rst_n), .i_req(req), .i_addr(ba),
		.i_stall(stall), .i_nack_addr(nack_at), .o_ack(ack), .o_nack(nk), .o_data(rdat));
	task chk(input string nm, input logic [47:0] s, input logic [47:0] e);
		checked++;
		if (s !== e) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	// Sink stalls three cycles in four so the buffer fills
	always @(posedge clk) begin
		rdy <= ($random(seed) & 3) == 0;
		if (wv && rdy) begin
			if (exp_q.size() == 0) chk("extra", 48'h1, 48'h0);
			else chk("write", {wa, wd}, exp_q.pop_front());
		end
	end
	task blk(input logic [1:0] t, input logic [13:0] a, input int cnt);
		logic [31:0] d;
		img.push_back(a[7:0]);
		img.push_back({t, a[13:8]});
		// Count goes low byte first
		if (t == cfg_loader_pkg::BLK_SEQ) img.push_back(cnt[7:0]);
		if (t == cfg_loader_pkg::BLK_SEQ) img.push_back(cnt[15:8]);
		for (int i = 0; i < cnt; i++) begin
			d = $random(seed);
			exp_q.push_back({a + 14'(i), 2'h0, d});
			for (int j = 0; j < 4; j++) img.push_back(d[8*j+:8]);
		end
	endtask : blk
	// Done block: complement of the sum with the checksum taken as zero
	task done_blk(input logic bad);
		sum = 8'hC0;
		foreach (img[i]) sum = sum + img[i];
		img.push_back(~sum ^ {7'h00, bad});
		img.push_back(8'hC0);
	endtask : done_blk
	task run(input int kind);
		img.delete();
		exp_q.delete();
		blk(cfg_loader_pkg::BLK_SINGLE, 14'($random(seed)) & 14'h1FFF, 1);
		blk(cfg_loader_pkg::BLK_SEQ, 14'($random(seed)) & 14'h1FF0, 1 + ($random(seed) & 7));
		blk(cfg_loader_pkg::BLK_SINGLE, 14'h2004, 1);
		if (kind == 3) blk(cfg_loader_pkg::BLK_BAD, 14'h0000, 0);
		done_blk(kind == 1 || kind == 2);
		exp_copy = exp_q;
		foreach (img[i]) i_eeprom_model.mem[i] = img[i];
		@(posedge clk);
		rst_n <= 1'b0;
		strap <= $random(seed);
		ast <= $random(seed);
		mode <= (kind == 7) ? 4'h2 : {3'h0, 1'($random(seed))};
		ign <= (kind == 2);
		nack_at <= (kind == 4) ? 16'h0003 : 16'hFFFF;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		if (kind == 7) begin
			repeat (20) @(posedge clk);
			chk("idle", {req, hold}, 48'h0);
			return;
		end
		if (kind == 5 || kind == 6) begin
			for (n = 0; n < 100 && req !== 1'b1; n++) @(negedge clk);
			@(posedge clk);
			// Let an answer already under way land first, so no pulse meets an ack
			stall <= 1'b1;
			repeat (2) @(posedge clk);
			repeat (kind == 6 ? 16 : 1) begin
				arb <= (kind == 6);
				misp <= (kind == 5);
				@(posedge clk);
				arb <= 1'b0;
				misp <= 1'b0;
				@(posedge clk);
			end
			stall <= 1'b0;
		end
		for (n = 0; n < 5000 && st.eeprom_load_done !== 1'b1; n++) @(negedge clk);
		ex = {kind < 4 || kind == 8, kind == 1 || kind == 3, kind == 4, kind == 6, kind == 5, 1'b1};
		chk("status", st, ex);
		chk("halt", {halt, hold}, {2{ex[4:1] != 4'h0}});
		chk("presc", presc, strap ? cfg_loader_pkg::PRESC_100K : cfg_loader_pkg::PRESC_400K);
		chk("dev", dev, {3'h5, ast});
		if (kind < 4 || kind == 8) chk("left", exp_q.size(), 48'h0);
		if (kind == 8) begin
			// Hot reset must clear done, hold the switch again and replay the image
			exp_q = exp_copy;
			@(posedge clk);
			hot <= 1'b1;
			@(posedge clk);
			hot <= 1'b0;
			@(negedge clk);
			chk("reload", {st.eeprom_load_done, hold}, 48'h1);
			for (n = 0; n < 5000 && st.eeprom_load_done !== 1'b1; n++) @(negedge clk);
			chk("rerun", {st, halt, hold}, {ex, 2'h0});
			chk("left", exp_q.size(), 48'h0);
		end
	endtask : run
	task complete_run;
		$display("Errors %0d checks %0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : complete_run
	initial begin
		for (k = 0; k < 11; k++) run(k > 8 ? 0 : k);
		complete_run();
	end
	// Watchdog well past eleven loads
	initial begin
		#(100 * 90000);
		error_cnt++;
		complete_run();
	end
endmodule : test_smbus_eeprom_config_loader
